// file: hw/vpsc_map.vh
`ifndef VPSC_MAP_VH
`define VPSC_MAP_VH

// ****************************************
// register location
// ****************************************
`define VPSC_OFFSET 12'h1dc
`define VPSC_MII_INDEX 5'h1f

// ****************************************
// field positions
// ****************************************
`define VPSC_BIT_MODE2 15
`define VPSC_BIT_LOOP 14
`define VPSC_BIT_MODE1 9
`define VPSC_BIT_MODE0 8
`define VPSC_BIT_COLTEST 7
`define VPSC_BIT_CLKDIR 6
`define VPSC_BIT_CLKSTR 5
`define VPSC_BIT_SPD_HI 4
`define VPSC_BIT_SPD_LO 2

// ****************************************
// reset values and modes
// ****************************************
`define VPSC_RST_LOOP 1'b0
`define VPSC_RST_COLTEST 1'b0
`define VPSC_MODE_RMII_MAC 3'h2
`define VPSC_MODE_RMII_PHY 3'h3

// ****************************************
// timing
// ****************************************
`define VPSC_CLK_DIV 8'h05
`define VPSC_STRAP_WAIT 2'h2
`define VPSC_STRAP_DONE 2'h3

`endif

// file: hw/vpsc_special_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "vpsc_map.vh"
// Summary of operation
// RL1: loopback returns fabric transmit into switch engine
// RL2: software sets receive-own-transmit for half duplex
// RL3: loopback works while isolate is set
// RL4: read-only mode from bit15 and bits9:8
// RL5: collision test asserts collision during transmit
// RL6: software uses collision test only with loopback
// RL7: clock direction bit sets reference pin role
// RL8: clock strength selects 12 or 16 mA; code drives 16 mA only in the two rmii modes
// RL9: loopback and collision test reset zero
// RL10: clock bits reset by emulated soft reset
// RL11: management reads give sixteen bits only
// RL12: reserved bits read zero, ignore writes
module vpsc_special_ctrl (
  input wire CORE_CLK,
  input wire RESETN,
  input wire HOST_WR,
  input wire HOST_RD,
  input wire [11:0] HOST_ADDR,
  input wire [31:0] HOST_WDATA,
  output reg [31:0] HOST_RDATA,
  input wire MII_WR,
  input wire MII_RD,
  input wire [4:0] MII_REG_ADDR,
  input wire [15:0] MII_WDATA,
  output reg [15:0] MII_RDATA,
  input wire [2:0] PORT_ZERO_MODE_STRAPS,
  input wire CLK_DIR_STRAP,
  input wire CLK_STRENGTH_STRAP,
  input wire [2:0] SPEED_DUPLEX,
  input wire EMU_PHY_ISOLATE_BIT,
  input wire SOFT_RESET_CLEARABLE,
  input wire EMU_PHY_RESET_BIT,
  input wire FABRIC_TX_EN,
  input wire [1:0] FABRIC_TXD,
  output reg [1:0] FABRIC_RXD,
  output reg FABRIC_RX_DV,
  output reg FABRIC_COL,
  output reg [1:0] EXT_TXD,
  output reg EXT_TX_EN,
  input wire EXT_RX_DV,
  input wire [1:0] EXT_RXD,
  input wire PORT_REF_CLOCK_PIN_IN,
  output reg PORT_REF_CLOCK_PIN_OUT,
  output wire PORT_REF_CLOCK_PIN_OE,
  output wire CLK_DRIVE_16MA,
  output wire REF_CLK_EDGE
);
  // ****************************************
  // state
  // ****************************************
  reg loop_en;
  reg col_test;
  reg clk_dir;
  reg clk_str;
  reg [2:0] mode;
  reg [1:0] strap_cnt;
  reg [7:0] div_cnt;
  reg ref_prev;
  wire [2:0] ext_rx_s;
  wire [4:0] straps_s;
  wire ref_in_s;
  wire host_hit;
  wire mii_hit;
  wire [15:0] reg_val;
  wire soft_rst;
  wire wr_any;
  wire [3:0] wr_val;
  wire div_tick;

  vpsc_sync #(.WIDTH(3)) u_sync_rx (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .d({EXT_RX_DV, EXT_RXD}),
    .q(ext_rx_s)
  );

  // all strap pins share one synchroniser and are read only after it has settled
  vpsc_sync #(.WIDTH(5)) u_sync_strap (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .d({CLK_DIR_STRAP, CLK_STRENGTH_STRAP, PORT_ZERO_MODE_STRAPS}),
    .q(straps_s)
  );

  vpsc_sync #(.WIDTH(1)) u_sync_ref (
    .clk(CORE_CLK),
    .resetn(RESETN),
    .d(PORT_REF_CLOCK_PIN_IN),
    .q(ref_in_s)
  );

  assign host_hit = (HOST_ADDR == `VPSC_OFFSET);
  assign mii_hit = (MII_REG_ADDR == `VPSC_MII_INDEX);
  // either reset source alone restores the clock bits
  assign soft_rst = SOFT_RESET_CLEARABLE | EMU_PHY_RESET_BIT; // RL10

  // ****************************************
  // register bank
  // ****************************************
  // both access paths write the same fields; the host wins a same-cycle clash
  function [3:0] wr_fields;
    input [15:0] data;
    begin
      wr_fields = {data[`VPSC_BIT_LOOP], data[`VPSC_BIT_COLTEST], data[`VPSC_BIT_CLKDIR],
                   data[`VPSC_BIT_CLKSTR]};
    end
  endfunction

  assign wr_any = (HOST_WR && host_hit) || (MII_WR && mii_hit);
  assign wr_val = (HOST_WR && host_hit) ? wr_fields(HOST_WDATA[15:0]) : wr_fields(MII_WDATA);

  // straps are caught once the synchroniser holds them; writes wait until then
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      strap_cnt <= 2'h0;
      mode <= 3'h0;
      clk_dir <= 1'b0;
      clk_str <= 1'b0;
    end else if (strap_cnt != `VPSC_STRAP_DONE) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == `VPSC_STRAP_WAIT) begin
        mode <= straps_s[2:0];
        clk_dir <= straps_s[4];
        clk_str <= straps_s[3];
      end
    end else if (soft_rst) begin
      clk_dir <= straps_s[4]; // RL10
      clk_str <= straps_s[3]; // RL10
    end else if (wr_any) begin
      clk_dir <= wr_val[1]; // RL7
      clk_str <= wr_val[0]; // RL8
    end
  end

  // loop and collision test are not cleared by the soft reset, so no write is lost to it
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      loop_en <= `VPSC_RST_LOOP; // RL9
      col_test <= `VPSC_RST_COLTEST; // RL9
    end else if (wr_any && strap_cnt == `VPSC_STRAP_DONE) begin
      loop_en <= wr_val[3];
      col_test <= wr_val[2];
    end
  end

  // reserved bits are constant zero and have no storage
  assign reg_val = {mode[2], loop_en, 4'h0, mode[1:0], col_test, clk_dir, clk_str,
                    SPEED_DUPLEX, 2'b00}; // RL4 RL12

  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      HOST_RDATA <= 32'h0000_0000;
      MII_RDATA <= 16'h0000;
    end else begin
      HOST_RDATA <= (HOST_RD && host_hit) ? {16'h0000, reg_val} : 32'h0000_0000; // RL12
      MII_RDATA <= (MII_RD && mii_hit) ? reg_val : 16'h0000; // RL11
    end
  end

  // ****************************************
  // data path
  // ****************************************
  // isolate only gates the external side; the loop path ignores it
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      EXT_TXD <= 2'b00;
      EXT_TX_EN <= 1'b0;
      FABRIC_RXD <= 2'b00;
      FABRIC_RX_DV <= 1'b0;
      FABRIC_COL <= 1'b0;
    end else begin
      if (loop_en) begin
        EXT_TX_EN <= 1'b0; // RL1
        EXT_TXD <= 2'b00;
        FABRIC_RX_DV <= FABRIC_TX_EN; // RL1 RL3
        FABRIC_RXD <= FABRIC_TXD;
      end else begin
        EXT_TX_EN <= FABRIC_TX_EN & ~EMU_PHY_ISOLATE_BIT;
        EXT_TXD <= EMU_PHY_ISOLATE_BIT ? 2'b00 : FABRIC_TXD;
        FABRIC_RX_DV <= ext_rx_s[2] & ~EMU_PHY_ISOLATE_BIT;
        FABRIC_RXD <= ext_rx_s[1:0];
      end
      FABRIC_COL <= col_test & FABRIC_TX_EN; // RL5
    end
  end

  // ****************************************
  // reference clock pin
  // ****************************************
  // output clock is a divider on the core clock, no second domain
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_cnt <= 8'h00;
      PORT_REF_CLOCK_PIN_OUT <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_prev <= ref_in_s;
      if (div_tick) begin
        div_cnt <= 8'h00;
        PORT_REF_CLOCK_PIN_OUT <= ~PORT_REF_CLOCK_PIN_OUT;
      end else begin
        div_cnt <= div_cnt + 8'h01;
      end
    end
  end

  // the strength bit only reaches the pad in the two rmii modes
  function is_rmii;
    input [2:0] code;
    begin
      is_rmii = (code == `VPSC_MODE_RMII_MAC) || (code == `VPSC_MODE_RMII_PHY);
    end
  endfunction

  // divider tick is a one-cycle enable; the pin toggles on it, no second clock
  assign div_tick = (div_cnt == `VPSC_CLK_DIV - 8'h01);
  assign PORT_REF_CLOCK_PIN_OE = clk_dir; // RL7
  // edges are only reported while the pin is an input
  assign REF_CLK_EDGE = ~clk_dir & ref_in_s & ~ref_prev;
  assign CLK_DRIVE_16MA = clk_str & is_rmii(mode); // RL8
endmodule
`default_nettype wire

// file: hw/vpsc_sync.v
`timescale 1ns/1ps
`default_nettype none
module vpsc_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire resetn,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// file: sim/vpsc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module vpsc_partner (
  input wire logic clk,
  input wire logic oe,
  input wire logic send,
  output logic ref_in,
  output logic rx_dv,
  output logic [1:0] rxd
);
  initial ref_in = 1'b0;
  initial rx_dv = 1'b0;
  initial rxd = 2'h0;
  // held while the device drives the pin, so the two never fight
  always #40 ref_in = oe ? ref_in : ~ref_in;
  always @(posedge clk) begin
    rx_dv <= send;
    // idle lines wander so stale data is never mistaken for a frame
    rxd <= send ? 2'h1 : ~rxd;
  end
endmodule
`default_nettype wire

// file: sim/vpsc_special_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module vpsc_special_ctrl_bench;
  logic CORE_CLK = 0, RESETN = 0, HOST_WR = 0, HOST_RD = 0, MII_WR = 0, MII_RD = 0, send = 0;
  logic EMU_PHY_ISOLATE_BIT = 0, SOFT_RESET_CLEARABLE = 0, EMU_PHY_RESET_BIT = 0, FABRIC_TX_EN = 0;
  logic FABRIC_RX_DV, FABRIC_COL, EXT_TX_EN, EXT_RX_DV, ref_in, PORT_REF_CLOCK_PIN_OUT;
  logic PORT_REF_CLOCK_PIN_OE, CLK_DRIVE_16MA, REF_CLK_EDGE;
  logic CLK_DIR_STRAP = 0, CLK_STRENGTH_STRAP = 0;
  logic [1:0] FABRIC_TXD = 0, FABRIC_RXD, EXT_TXD, EXT_RXD;
  logic [2:0] PORT_ZERO_MODE_STRAPS = 0, s;
  logic [4:0] MII_REG_ADDR = 0;
  logic [11:0] HOST_ADDR = 0;
  logic [15:0] MII_WDATA = 0, MII_RDATA;
  logic [31:0] HOST_WDATA = 0, HOST_RDATA;
  int n_fail = 0, num_checks = 0, i, n;
  wire ref_pin = PORT_REF_CLOCK_PIN_OE ? PORT_REF_CLOCK_PIN_OUT : ref_in;
  always #2 CORE_CLK = ~CORE_CLK;
  vpsc_special_ctrl vpsc_special_ctrl_inst (.*, .PORT_REF_CLOCK_PIN_IN(ref_pin),
    .SPEED_DUPLEX(3'h5));
  vpsc_partner vpsc_partner_inst (.clk(CORE_CLK), .oe(PORT_REF_CLOCK_PIN_OE), .send(send),
    .ref_in(ref_in), .rx_dv(EXT_RX_DV), .rxd(EXT_RXD));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // m selects the management port, w a write; a read compares against d
  task xfer(input bit m, input bit w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    {HOST_ADDR, MII_REG_ADDR, HOST_WDATA, MII_WDATA} <= {a, a[4:0], d, d[15:0]};
    {HOST_WR, HOST_RD, MII_WR, MII_RD} <= {!m && w, !m && !w, m && w, m && !w};
    @(posedge CORE_CLK);
    {HOST_WR, HOST_RD, MII_WR, MII_RD} <= 4'h0;
    #1;
    if (!w) chk(m ? {16'h0, MII_RDATA} : HOST_RDATA, d);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    report_and_stop;
  end
  initial begin
    for (i = 3; i < 8; i++) begin
      s = 3'(i % 5);
      @(posedge CORE_CLK);
      PORT_ZERO_MODE_STRAPS <= s;
      {CLK_DIR_STRAP, CLK_STRENGTH_STRAP} <= s[1:0];
      RESETN <= 0;
      repeat (8) @(posedge CORE_CLK);
      RESETN <= 1;
      repeat (4) @(posedge CORE_CLK);
      xfer(0, 0, 12'h1dc, {16'h0, s[2], 5'h0, s[1:0], 1'b0, s[1:0], 5'h14});
      chk(CLK_DRIVE_16MA, s[0] && (s == 3'h2 || s == 3'h3));
    end
    xfer(0, 1, 12'h1dc, 32'hffffffff);
    xfer(0, 0, 12'h1dc, 32'h42f4);
    @(posedge CORE_CLK);
    EMU_PHY_ISOLATE_BIT <= 1;
    FABRIC_TX_EN <= 1;
    FABRIC_TXD <= 2'h3;
    xfer(0, 0, 12'h1dc, 32'h42f4);
    chk({FABRIC_RX_DV, FABRIC_RXD, FABRIC_COL, EXT_TX_EN}, 5'b11110);
    xfer(0, 1, 12'h1dc, 32'h0);
    @(posedge CORE_CLK);
    EMU_PHY_ISOLATE_BIT <= 0;
    xfer(0, 0, 12'h1dc, 32'h214);
    chk({FABRIC_COL, EXT_TX_EN, EXT_TXD, PORT_REF_CLOCK_PIN_OE, CLK_DRIVE_16MA}, 6'b011100);
    @(posedge CORE_CLK);
    FABRIC_TX_EN <= 0;
    send <= 1;
    n = 0;
    // the pulse comes straight off registers, so it is looked at away from the edge
    repeat (400) @(negedge CORE_CLK) n += REF_CLK_EDGE;
    chk(n >= 19 && n <= 21, 1);
    chk({FABRIC_RX_DV, FABRIC_RXD}, 3'b101);
    @(posedge CORE_CLK);
    send <= 0;
    SOFT_RESET_CLEARABLE <= 1;
    @(posedge CORE_CLK);
    SOFT_RESET_CLEARABLE <= 0;
    xfer(0, 0, 12'h1dc, 32'h254);
    xfer(0, 1, 12'h1dc, 32'h0);
    @(posedge CORE_CLK);
    EMU_PHY_RESET_BIT <= 1;
    @(posedge CORE_CLK);
    EMU_PHY_RESET_BIT <= 0;
    xfer(0, 0, 12'h1dc, 32'h254);
    xfer(0, 1, 12'h1e0, 32'hffffffff);
    xfer(0, 0, 12'h1e0, 32'h0);
    xfer(1, 1, 12'h1f, 32'h4000);
    xfer(1, 0, 12'h1f, 32'h4214);
    xfer(0, 0, 12'h1dc, 32'h4214);
    report_and_stop;
  end
endmodule
`default_nettype wire

// file: sim/vpsc_special_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module vpsc_props (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic HOST_RD,
  input wire logic [11:0] HOST_ADDR,
  input wire logic [31:0] HOST_RDATA,
  input wire logic FABRIC_TX_EN,
  input wire logic FABRIC_COL,
  input wire logic FABRIC_RX_DV,
  input wire logic EXT_TX_EN,
  input wire logic PORT_REF_CLOCK_PIN_OE,
  input wire logic CLK_DRIVE_16MA
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  wire hit = HOST_RD && HOST_ADDR == 12'h1dc;
  a_rsvd_high: assert property (HOST_RDATA[31:16] == 16'h0) else $error("pad bits");
  a_rsvd_mid: assert property (HOST_RDATA[13:10] == 4'h0) else $error("rsvd bits");
  a_unmapped_zero: assert property (HOST_RD && !hit |=> HOST_RDATA == 0)
    else $error("unmapped read");
  a_dir_read: assert property (hit |=> HOST_RDATA[6] == $past(PORT_REF_CLOCK_PIN_OE))
    else $error("clock direction");
  a_drive_read: assert property (hit |=>
    $past(CLK_DRIVE_16MA) == (HOST_RDATA[5] && !HOST_RDATA[15] && HOST_RDATA[9]))
    else $error("clock strength");
  a_col_cause: assert property (FABRIC_COL |-> $past(FABRIC_TX_EN)) else $error("col");
  a_loop_cut: assert property (hit && FABRIC_TX_EN ##1 HOST_RDATA[14] |->
    !EXT_TX_EN && FABRIC_RX_DV) else $error("loopback");
  a_col_test: assert property (hit && FABRIC_TX_EN ##1 HOST_RDATA[7] |-> FABRIC_COL)
    else $error("collision test");
  cover property (FABRIC_COL);
  cover property (FABRIC_RX_DV && !EXT_TX_EN);
  cover property (CLK_DRIVE_16MA);
endmodule
bind vpsc_special_ctrl vpsc_props vpsc_props_inst (.*);
`default_nettype wire
